//--- hdl/mac_status_cfg.svh
// offsets, field positions and reset values of the mac status block
`ifndef MAC_STATUS_CFG_SVH
`define MAC_STATUS_CFG_SVH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define ADDR_RX_FIFO 32'h400F_0200
`define ADDR_TX_FIFO 32'h400F_0204
`define ADDR_ACC 32'h400F_0208
`define ADDR_RX_ENA 32'h400F_0220
`define ADDR_QUEUE 32'h400F_1100
`define ADDR_RESET 32'h400F_0030
`define ADDR_RX_MODE 32'h400F_0240
`define ADDR_RX_READY 32'h400F_0244
`define ADDR_TX_MODE 32'h400F_0248
// ----------------------------------------
// field positions
// ----------------------------------------
`define RXF_FULL_BIT 31
`define RXF_EMPTY_BIT 30
`define RXF_READY_BIT 29
`define RXF_COUNT_LSB 17
`define TXF_FULL_BIT 31
`define TXF_EMPTY_BIT 30
`define TXF_STATE_LSB 27
`define TXF_RESULT_LSB 24
`define RST_ALL_BIT 31
`define RST_TX_BIT 15
`define RST_RX_BIT 14
`define RXM_FULL_LSB 16
`define RXM_EMPTY_LSB 0
`define TXM_EMPTY_LSB 11
`define TXM_FULL_LSB 9
`define DESC_NOT_EMPTY_BIT 31
`define DESC_VALID_BIT 28
`define DESC_WORD_LSB 16
// ----------------------------------------
// reset values and sizes
// ----------------------------------------
`define ACC_RESET 3'h3
`define RX_ENA_RESET 1'h1
`define RX_THRESH_RESET 12'h000
`define TX_EMPTY_CODE_RESET 3'h0
`define TX_FULL_CODE_RESET 2'h0
`define TX_THRESH_BASE 12'h004
`define QUEUE_DEPTH 64
`define QUEUE_COUNT_FULL 7'h40
`endif

//--- hdl/mac_status_pkg.sv
// shared types of the mac status block
package mac_status_pkg;
  typedef logic [31:0] word_t;
  typedef logic [11:0] count_t;
  typedef struct packed {
    logic valid;
    count_t words;
    logic [15:0] addr;
  } desc_s;
endpackage

//--- hdl/mac_fifo_status_rx_queue.sv
// fifo status, accelerator control and receive descriptor queue of the mac
//
// The Wishbone register port is this design's own decision.
`include "mac_status_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module mac_fifo_status_rx_queue (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [31:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  input wire logic [11:0] RX_FIFO_WORDS,
  input wire logic [11:0] RX_FIFO_FREE,
  input wire logic [11:0] TX_FIFO_WORDS,
  input wire logic [11:0] TX_FIFO_FREE,
  input wire logic [2:0] TX_FIFO_STATE,
  input wire logic [2:0] TX_RESULT_FRAMES,
  input wire logic DMA_DONE,
  input wire logic DMA_DESC_VALID,
  input wire logic [11:0] DMA_DESC_WORDS,
  input wire logic [15:0] DMA_DESC_ADDR,
  output logic RX_CHECKSUM_OFF,
  output logic TX_ACCEL_ENABLE,
  output logic RX_ACCEL_ENABLE,
  output logic RX_MAC_ENABLE,
  output logic RX_COMPLETION_IRQ,
  output logic TX_PATH_RESET,
  output logic RX_PATH_RESET,
  output logic MODULE_RESET
);
  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic [2:0] acc;
  logic rx_ena;
  logic [11:0] rx_full_threshold;
  logic [11:0] rx_empty_threshold;
  logic [11:0] rx_ready_threshold;
  logic [2:0] tx_empty_threshold;
  logic [1:0] tx_full_threshold;
  logic ack;
  logic [31:0] rdat;
  logic [6:0] count;
  logic [5:0] wr_ptr;
  logic [5:0] rd_ptr;
  logic irq;
  logic tx_rst;
  logic rx_rst;
  logic all_rst;
  mac_status_pkg::desc_s queue [`QUEUE_DEPTH];

  // soft reset takes the whole block down one cycle after its write
  wire rst = !RST_N || all_rst;
  wire access = CYC_I && STB_I && !ack;
  wire wr = access && WE_I;
  wire rd = access && !WE_I;
  wire hit_rxf = ADR_I == `ADDR_RX_FIFO;
  wire hit_txf = ADR_I == `ADDR_TX_FIFO;
  wire hit_acc = ADR_I == `ADDR_ACC;
  wire hit_ena = ADR_I == `ADDR_RX_ENA;
  wire hit_queue = ADR_I == `ADDR_QUEUE;
  wire hit_reset = ADR_I == `ADDR_RESET;
  wire hit_rxm = ADR_I == `ADDR_RX_MODE;
  wire hit_rxr = ADR_I == `ADDR_RX_READY;
  wire hit_txm = ADR_I == `ADDR_TX_MODE;
  wire [31:0] lane = {{8{SEL_I[3]}}, {8{SEL_I[2]}}, {8{SEL_I[1]}}, {8{SEL_I[0]}}};
  wire [31:0] wmask = lane & DAT_I;

  // ----------------------------------------
  // live fifo status
  // ----------------------------------------
  // tx thresholds are 4 << code; recomputed combinationally each cycle
  wire [11:0] tx_empty_words = `TX_THRESH_BASE << tx_empty_threshold;
  wire [11:0] tx_full_words = `TX_THRESH_BASE << tx_full_threshold;
  wire rx_full_flag = RX_FIFO_FREE <= rx_full_threshold;
  wire rx_empty_flag = RX_FIFO_WORDS <= rx_empty_threshold;
  wire rx_ready_flag = RX_FIFO_WORDS > rx_ready_threshold;
  wire tx_full_flag = TX_FIFO_FREE < tx_full_words;
  wire tx_empty_flag = TX_FIFO_WORDS <= tx_empty_words;

  logic [31:0] rx_status;
  logic [31:0] tx_status;
  always_comb begin
    rx_status = 32'h0000_0000;
    rx_status[`RXF_FULL_BIT] = rx_full_flag;
    rx_status[`RXF_EMPTY_BIT] = rx_empty_flag;
    rx_status[`RXF_READY_BIT] = rx_ready_flag;
    rx_status[`RXF_COUNT_LSB +: 12] = RX_FIFO_WORDS;
    tx_status = 32'h0000_0000;
    tx_status[`TXF_FULL_BIT] = tx_full_flag;
    tx_status[`TXF_EMPTY_BIT] = tx_empty_flag;
    tx_status[`TXF_STATE_LSB +: 3] = TX_FIFO_STATE;
    tx_status[`TXF_RESULT_LSB +: 3] = TX_RESULT_FRAMES;
  end

  // ----------------------------------------
  // descriptor queue
  // ----------------------------------------
  mac_status_pkg::desc_s head;
  assign head = queue[rd_ptr];
  wire not_empty = count != 7'h00;
  // a completion arriving with the queue full is dropped; 64 is the limit
  wire push = DMA_DONE && (count != `QUEUE_COUNT_FULL);
  wire pop = rd && hit_queue && not_empty;
  logic [6:0] next_count;
  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 7'h01;
    end else if (pop && !push) begin
      next_count = count - 7'h01;
    end
  end

  logic [31:0] queue_word;
  always_comb begin
    queue_word = 32'h0000_0000;
    if (not_empty) begin
      queue_word[`DESC_NOT_EMPTY_BIT] = 1'b1;
      queue_word[`DESC_VALID_BIT] = head.valid;
      queue_word[`DESC_WORD_LSB +: 12] = head.words;
      queue_word[15:0] = head.addr;
    end
  end

  always_ff @(posedge CLK) begin
    if (push) begin
      queue[wr_ptr] <= '{valid: DMA_DESC_VALID, words: DMA_DESC_WORDS,
        addr: DMA_DESC_ADDR};
    end
  end

  always_ff @(posedge CLK) begin
    if (rst) begin
      count <= 7'h00;
      wr_ptr <= 6'h00;
      rd_ptr <= 6'h00;
      irq <= 1'b0;
    end else begin
      count <= next_count;
      if (push) begin
        wr_ptr <= wr_ptr + 6'h01;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 6'h01;
      end
      // level interrupt follows occupancy, drops once the last entry is read
      irq <= next_count != 7'h00;
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_rxf) begin
      rd_mux = rx_status;
    end else if (hit_txf) begin
      rd_mux = tx_status;
    end else if (hit_acc) begin
      rd_mux = {29'h0000_0000, acc};
    end else if (hit_ena) begin
      rd_mux = {31'h0000_0000, rx_ena};
    end else if (hit_queue) begin
      rd_mux = queue_word;
    end else if (hit_rxm) begin
      rd_mux[`RXM_FULL_LSB +: 12] = rx_full_threshold;
      rd_mux[`RXM_EMPTY_LSB +: 12] = rx_empty_threshold;
    end else if (hit_rxr) begin
      rd_mux = {20'h0_0000, rx_ready_threshold};
    end else if (hit_txm) begin
      rd_mux[`TXM_EMPTY_LSB +: 3] = tx_empty_threshold;
      rd_mux[`TXM_FULL_LSB +: 2] = tx_full_threshold;
    end
  end

  // ----------------------------------------
  // bus answer
  // ----------------------------------------
  // every access, mapped or not, is answered one cycle after it starts
  always_ff @(posedge CLK) begin
    if (rst) begin
      ack <= 1'b0;
      rdat <= 32'h0000_0000;
    end else begin
      ack <= access;
      if (rd) begin
        rdat <= rd_mux;
      end
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (rst) begin
      acc <= `ACC_RESET;
      rx_ena <= `RX_ENA_RESET;
    end else if (wr && SEL_I[0]) begin
      if (hit_acc) begin
        acc <= DAT_I[2:0];
      end
      if (hit_ena) begin
        rx_ena <= DAT_I[0];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (rst) begin
      rx_full_threshold <= `RX_THRESH_RESET;
      rx_empty_threshold <= `RX_THRESH_RESET;
      rx_ready_threshold <= `RX_THRESH_RESET;
    end else if (wr) begin
      if (hit_rxm) begin
        rx_full_threshold <= (rx_full_threshold & ~lane[`RXM_FULL_LSB +: 12])
          | wmask[`RXM_FULL_LSB +: 12];
        rx_empty_threshold <= (rx_empty_threshold & ~lane[`RXM_EMPTY_LSB +: 12])
          | wmask[`RXM_EMPTY_LSB +: 12];
      end
      if (hit_rxr) begin
        rx_ready_threshold <= (rx_ready_threshold & ~lane[11:0]) | wmask[11:0];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (rst) begin
      tx_empty_threshold <= `TX_EMPTY_CODE_RESET;
      tx_full_threshold <= `TX_FULL_CODE_RESET;
    end else if (wr && hit_txm && SEL_I[1]) begin
      tx_empty_threshold <= DAT_I[`TXM_EMPTY_LSB +: 3];
      tx_full_threshold <= DAT_I[`TXM_FULL_LSB +: 2];
    end
  end

  // ----------------------------------------
  // reset strobes
  // ----------------------------------------
  // write-only pulses of one cycle; the register reads as zero
  wire rst_write = wr && hit_reset;
  always_ff @(posedge CLK) begin
    if (rst) begin
      tx_rst <= 1'b0;
      rx_rst <= 1'b0;
      all_rst <= 1'b0;
    end else begin
      tx_rst <= rst_write && SEL_I[1] && DAT_I[`RST_TX_BIT];
      rx_rst <= rst_write && SEL_I[1] && DAT_I[`RST_RX_BIT];
      all_rst <= rst_write && SEL_I[3] && DAT_I[`RST_ALL_BIT];
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign ACK_O = ack;
  assign DAT_O = rdat;
  assign RX_CHECKSUM_OFF = acc[2];
  assign TX_ACCEL_ENABLE = acc[1];
  assign RX_ACCEL_ENABLE = acc[0];
  assign RX_MAC_ENABLE = rx_ena;
  assign RX_COMPLETION_IRQ = irq;
  assign TX_PATH_RESET = tx_rst;
  assign RX_PATH_RESET = rx_rst;
  assign MODULE_RESET = all_rst;
endmodule
`default_nettype wire

//--- verif/mac_status_assertions.sv
// concurrent checks on the ports of the mac status block
`timescale 1ns/100ps
`default_nettype none
`include "mac_status_cfg.svh"
module mac_status_assertions (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [31:0] ADR_I,
  input wire logic [31:0] DAT_I,
  input wire logic [31:0] DAT_O,
  input wire logic ACK_O,
  input wire logic [11:0] RX_FIFO_WORDS,
  input wire logic [2:0] TX_FIFO_STATE,
  input wire logic [2:0] TX_RESULT_FRAMES,
  input wire logic DMA_DONE,
  input wire logic RX_CHECKSUM_OFF,
  input wire logic TX_ACCEL_ENABLE,
  input wire logic RX_MAC_ENABLE,
  input wire logic RX_COMPLETION_IRQ,
  input wire logic TX_PATH_RESET,
  input wire logic RX_PATH_RESET,
  input wire logic MODULE_RESET
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  wire logic take = CYC_I && STB_I && !ACK_O;
  // ---
  // bus and status
  // ---
  a_ack_pulse: assert property (ACK_O |=> !ACK_O)
    else $error("ack longer than one cycle");
  a_ack_follows: assert property (take |=> ACK_O)
    else $error("request not answered next cycle");
  a_rx_count: assert property (ACK_O && $past(ADR_I) == `ADDR_RX_FIFO && !$past(WE_I)
    |-> DAT_O[28:17] == $past(RX_FIFO_WORDS))
    else $error("rx word count field wrong");
  a_tx_fields: assert property (ACK_O && $past(ADR_I) == `ADDR_TX_FIFO && !$past(WE_I)
    |-> DAT_O[29:24] == {$past(TX_FIFO_STATE), $past(TX_RESULT_FRAMES)})
    else $error("tx state or frame field wrong");
  // ---
  // queue and resets
  // ---
  a_irq_rise: assert property (DMA_DONE && !RX_COMPLETION_IRQ && !take && !MODULE_RESET
    |=> RX_COMPLETION_IRQ)
    else $error("push did not raise irq");
  a_irq_hold: assert property (RX_COMPLETION_IRQ && !take && !MODULE_RESET
    |=> RX_COMPLETION_IRQ)
    else $error("irq dropped without a read");
  a_not_empty: assert property (ACK_O && $past(ADR_I) == `ADDR_QUEUE && !$past(WE_I)
    && !$past(DMA_DONE) |-> DAT_O[31] == $past(RX_COMPLETION_IRQ))
    else $error("not-empty flag disagrees with irq");
  a_tx_strobe: assert property ($rose(TX_PATH_RESET) |-> $past(take && WE_I && DAT_I[15]
    && ADR_I == `ADDR_RESET))
    else $error("tx path reset without write");
  a_rx_strobe: assert property (RX_PATH_RESET |=> !RX_PATH_RESET)
    else $error("rx path reset longer than a pulse");
  a_mod_reset: assert property (MODULE_RESET |=> !RX_COMPLETION_IRQ && RX_MAC_ENABLE
    && TX_ACCEL_ENABLE && !RX_CHECKSUM_OFF)
    else $error("module reset left state behind");
  c_module_reset: cover property (MODULE_RESET);
  c_push_busy: cover property (DMA_DONE && RX_COMPLETION_IRQ);
  c_tx_reset: cover property (TX_PATH_RESET);
endmodule
`default_nettype wire

//--- verif/mac_side_model.sv
// dma completion and fifo level model behind the mac status block
`timescale 1ns/100ps
`default_nettype none
module mac_side_model (
  input wire logic clk,
  input wire logic push,
  input wire logic en,
  input wire logic [28:0] d,
  input wire logic [11:0] rx_w,
  input wire logic [11:0] tx_w,
  output logic done,
  output logic [28:0] desc,
  output logic [11:0] rx_f,
  output logic [11:0] tx_f
);
  // free space of a full-scale fifo mirrors its occupancy
  assign rx_f = 12'hFFF - rx_w;
  assign tx_f = 12'hFFF - tx_w;
  // a disabled receive mac moves no frame, so no transfer completes
  always_ff @(posedge clk) begin
    done <= push && en;
    // junk on the descriptor lines outside the pulse
    desc <= (push && en) ? d : ~desc;
  end
endmodule
`default_nettype wire

//--- verif/mac_fifo_status_rx_queue_tb.sv
// random and corner testbench of the mac status block
`timescale 1ns/100ps
`default_nettype none
`include "mac_status_cfg.svh"
module mac_fifo_status_rx_queue_tb;
  logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, push = 0;
  logic [31:0] adr = 0, wdat = 0, dat_o, r;
  logic [3:0] sel = 4'hF;
  logic [11:0] rx_w = 0, tx_w = 0, rx_f, tx_f;
  logic [2:0] st = 0, fr = 0, pul;
  logic [28:0] pd = 0, desc;
  logic ack, done, irq, cko, tae, rae, rme, tpr, rpr, mr;
  logic [31:0] q[$];
  int n_fail = 0, total_checks = 0;
  always #25 clk = ~clk;
  mac_side_model side_u (.clk(clk), .push(push), .en(rme), .d(pd), .rx_w(rx_w),
    .tx_w(tx_w), .done(done), .desc(desc), .rx_f(rx_f), .tx_f(tx_f));
  mac_fifo_status_rx_queue dut_u (.CLK(clk), .RST_N(rst_n), .CYC_I(cyc), .STB_I(stb),
    .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(dat_o), .ACK_O(ack),
    .RX_FIFO_WORDS(rx_w), .RX_FIFO_FREE(rx_f), .TX_FIFO_WORDS(tx_w), .TX_FIFO_FREE(tx_f),
    .TX_FIFO_STATE(st), .TX_RESULT_FRAMES(fr), .DMA_DONE(done), .DMA_DESC_VALID(desc[28]),
    .DMA_DESC_WORDS(desc[27:16]), .DMA_DESC_ADDR(desc[15:0]), .RX_CHECKSUM_OFF(cko),
    .TX_ACCEL_ENABLE(tae), .RX_ACCEL_ENABLE(rae), .RX_MAC_ENABLE(rme),
    .RX_COMPLETION_IRQ(irq), .TX_PATH_RESET(tpr), .RX_PATH_RESET(rpr), .MODULE_RESET(mr));
  // ---
  // helpers
  // ---
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    r = dat_o;
    pul = {mr, tpr, rpr};
    cyc <= 0;
    stb <= 0;
    if (n >= 20) n_fail++;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  function automatic logic [31:0] rx_exp(input logic [11:0] w, f, ft, et, rt);
    return {f <= ft, w <= et, w > rt, w, 17'h0};
  endfunction
  function automatic logic [31:0] tx_exp(input logic [11:0] w, f, input logic [2:0] ec,
    input logic [1:0] fc, input logic [2:0] s, n);
    return {f < (12'h004 << fc), w <= (12'h004 << ec), s, n, 24'h0};
  endfunction
  // ---
  // tests
  // ---
  initial begin
    logic [11:0] ft, et, rt, w1, w2;
    logic [2:0] ec;
    logic [1:0] fc;
    logic [28:0] v;
    logic [31:0] ra [4] = '{`ADDR_ACC, `ADDR_RX_ENA, `ADDR_QUEUE, 32'h400F_0300};
    logic [31:0] rv [4] = '{32'h3, 32'h1, 32'h0, 32'h0};
    void'($urandom(32'h3E2AAAB5));
    repeat (8) @(posedge clk);
    rst_n <= 1;
    for (int i = 0; i < 4; i++) begin
      wb(0, ra[i], 0);
      chk("reset read", rv[i], r);
    end
    for (int i = 0; i < 8; i++) begin
      wb(1, `ADDR_ACC, {29'h0, i[2:0]});
      wb(0, `ADDR_ACC, 0);
      chk("acc", {29'h0, i[2:0]}, r);
      chk("acc pins", {29'h0, i[2:0]}, {29'h0, cko, tae, rae});
    end
    // odd rounds sit the three rx thresholds exactly on the level
    for (int i = 0; i < 30; i++) begin
      {ft, et, rt, ec, fc} = 41'({$urandom, $urandom});
      w1 = (i < 4) ? 12'(i) : 12'($urandom);
      if (i[0]) {ft, et, rt} = {12'hFFF - w1, w1, w1};
      w2 = (i < 8) ? 12'(4 << ec) : (i < 16) ? 12'hFFB - 12'(4 << fc) + 12'(i[0]) : 12'($urandom);
      rx_w <= w1;
      tx_w <= w2;
      st <= i[2:0];
      fr <= 3'($urandom);
      wb(1, `ADDR_RX_MODE, {4'h0, ft, 4'h0, et});
      wb(1, `ADDR_RX_READY, {20'h0, rt});
      wb(1, `ADDR_TX_MODE, {18'h0, ec, fc, 9'h0});
      wb(0, `ADDR_RX_FIFO, 0);
      chk("rx status", rx_exp(w1, 12'hFFF - w1, ft, et, rt), r);
      wb(0, `ADDR_TX_FIFO, 0);
      chk("tx status", tx_exp(w2, 12'hFFF - w2, ec, fc, st, fr), r);
    end
    wb(1, `ADDR_RX_ENA, 0);
    chk("rx enable pin", 0, 32'(rme));
    push <= 1;
    @(posedge clk);
    push <= 0;
    repeat (3) @(posedge clk);
    chk("irq while disabled", 0, 32'(irq));
    wb(1, `ADDR_RX_ENA, 1);
    for (int i = 0; i < 65; i++) begin
      v = 29'($urandom);
      pd <= v;
      push <= 1;
      if (i < 64) q.push_back({3'b100, v});
      @(posedge clk);
    end
    push <= 0;
    repeat (3) @(posedge clk);
    chk("irq full", 1, 32'(irq));
    for (int i = 0; i < 65; i++) begin
      wb(0, `ADDR_QUEUE, 0);
      chk("descriptor", (i < 64) ? q[i] : 32'h0, r);
      if (i < 64) begin
        // software view: frame info sits two words before the end of the buffer
        chk("frame info address", (32'(q[i][15:0]) << 11) + 32'h0800_0000
          + ((32'(q[i][27:16]) - 32'h2) << 2), (32'(r[15:0]) << 11) + 32'h0800_0000
          + ((32'(r[27:16]) - 32'h2) << 2));
      end
    end
    chk("irq drained", 0, 32'(irq));
    wb(1, `ADDR_RESET, 32'h0000_C000);
    chk("path pulses", 32'h3, 32'(pul));
    wb(1, `ADDR_ACC, 0);
    push <= 1;
    @(posedge clk);
    push <= 0;
    wb(1, `ADDR_RESET, 32'h8000_0000);
    chk("module pulse", 32'h4, 32'(pul));
    wb(0, `ADDR_ACC, 0);
    chk("acc after module reset", 32'h3, r);
    chk("irq after module reset", 0, 32'(irq));
    end_sim;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_sim;
  end
endmodule
bind mac_fifo_status_rx_queue mac_status_assertions chk_u (.*);
`default_nettype wire
